// ==== hdl/mcu_memory_map_decode.sv ====
// program space sequencing, return stack and data space decode
`timescale 1ns/1ps
// Functional notes
// - program counter is twelve bits wide
// - six-entry twelve-bit hardware return stack
// - reset vector read from 0FFE/0FFF
// - nmi vector read from 0FFC/0FFD
// - maskable vectors lie in 0FF0-0FF7
// - 64-byte program memory window in data
// - 64-byte banks overlay data 00h-3Fh
// - sixty bytes general ram in data
// - low reset input restarts the device
// - raised test level at reset: programming
// - nmi taken on falling edge, pulled up
// - readout protection blocks external program reads
// - port lines software configurable per mode
// - timer bit switches b7; b6 input feeds
// - c1 timer, c2-c4 serial in/out/clock
// - window address joins register and offset
// - page2 bit routes bank region to ram
module mcu_memory_map_decode #(
  parameter int NLINES = 21
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // straps and events
  input  wire logic                   test_raised,
  input  wire logic                   nmi_pin,
  input  wire logic                   readout_protect,
  input  wire logic                   ext_read_req,
  // core requests
  input  wire logic                   irq_take,
  input  wire logic [2:0]             irq_index,
  input  wire logic                   call_req,
  input  wire logic                   ret_req,
  input  wire logic [11:0]            call_target,
  input  wire logic                   jump_req,
  // program memory
  output logic      [11:0]            prog_addr,
  input  wire logic [7:0]             prog_rdata,
  // data space access
  input  wire logic                   data_wr,
  input  wire logic                   data_rd,
  input  wire logic [7:0]             data_addr,
  input  wire logic [7:0]             data_wdata,
  output logic      [7:0]             data_rdata,
  output logic                        data_rvalid,
  // port lines
  input  wire mem_map_pkg::pin_mode_e line_mode [NLINES],
  input  wire logic [NLINES-1:0]      line_data,
  input  wire logic                   timer_out_sel,
  input  wire logic                   reload_timer_output,
  input  wire logic                   timer1_out,
  input  wire logic                   timer1_alt_en,
  input  wire logic                   spi_alt_en,
  input  wire logic                   spi_dout,
  input  wire logic                   spi_clk_out,
  input  wire logic [NLINES-1:0]      pad_in,
  output logic      [NLINES-1:0]      pad_out,
  output logic      [NLINES-1:0]      pad_oe,
  output logic      [NLINES-1:0]      pad_pullup,
  output logic      [NLINES-1:0]      line_in,
  output logic      [NLINES-1:0]      line_irq,
  output logic                        reload_timer_input,
  output logic                        spi_din,
  // status
  output logic      [11:0]            program_counter,
  output logic      [2:0]             stack_level,
  output logic                        prog_mode,
  output logic                        nmi_pending,
  output logic                        ext_read_blocked
);
  // lines: a0-a7 = 0..7, b0-b7 = 8..15, c0-c4 = 16..20
  localparam int port_b_bit6 = 14;
  localparam int port_b_bit7 = 15;
  localparam int port_c_bit1 = 17;
  localparam int port_c_bit2 = 18;
  localparam int port_c_bit3 = 19;
  localparam int port_c_bit4 = 20;

  mem_map_pkg::seq_e seq_q;
  logic [11:0] pc_q;
  logic [11:0] stack_q [mem_map_pkg::STACK_DEPTH];
  logic [2:0]  sp_q;
  logic [7:0]  vec_lo_q;
  logic [11:0] vec_addr_q;
  logic [5:0]  window_position_register;
  logic        ram_page2_select_bit;
  logic [1:0]  ee_sel_q;
  logic [7:0]  ram_q  [60];
  logic [7:0]  page2_q [64];
  logic        nmi_prev_q;
  logic        nmi_fall;
  logic        win_rd_q;
  logic [5:0]  win_ofs_q;
  logic [NLINES-1:0] alt_en;
  logic [NLINES-1:0] alt_out;
  logic [NLINES-1:0] pad_out_c;
  logic [NLINES-1:0] pad_oe_c;
  logic [NLINES-1:0] pullup_c;
  logic [NLINES-1:0] in_c;
  logic [NLINES-1:0] irq_c;

  // ----------------------------------------------------------------
  // program space sequencing
  // ----------------------------------------------------------------
  // falling edge of the nmi input
  assign nmi_fall = nmi_prev_q & ~nmi_pin;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nmi_prev_q  <= 1'b1;
      nmi_pending <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_pin;
      // new edge wins over the acknowledge
      if (nmi_fall) begin
        nmi_pending <= 1'b1;
      end else if (seq_q == mem_map_pkg::ST_VEC_HI && vec_addr_q == mem_map_pkg::NMI_VEC_HI) begin
        nmi_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_q      <= mem_map_pkg::ST_RESET;
      pc_q       <= '0;
      vec_lo_q   <= mem_map_pkg::RESET_BYTE;
      vec_addr_q <= mem_map_pkg::RESET_VEC_LO;
      sp_q       <= '0;
      prog_mode  <= 1'b0;
    end else begin
      case (seq_q)
        // strap sampled in the reset phase
        mem_map_pkg::ST_RESET: begin
          prog_mode <= test_raised;
          if (test_raised) begin
            seq_q <= mem_map_pkg::ST_PROG;
          end else begin
            vec_addr_q <= mem_map_pkg::RESET_VEC_LO;
            seq_q      <= mem_map_pkg::ST_VEC_LO;
          end
        end
        mem_map_pkg::ST_VEC_LO: begin
          vec_lo_q   <= prog_rdata;
          vec_addr_q <= vec_addr_q + 12'h0001;
          seq_q      <= mem_map_pkg::ST_VEC_HI;
        end
        mem_map_pkg::ST_VEC_HI: begin
          pc_q  <= {prog_rdata[3:0], vec_lo_q};
          seq_q <= mem_map_pkg::ST_RUN;
        end
        mem_map_pkg::ST_RUN: begin
          if (nmi_pending || irq_take) begin
            if (sp_q < 3'(mem_map_pkg::STACK_DEPTH)) begin
              stack_q[sp_q] <= pc_q;
              sp_q          <= sp_q + 3'd1;
            end
            vec_addr_q <= nmi_pending ? mem_map_pkg::NMI_VEC_LO
                        : mem_map_pkg::IRQ_VEC_BASE + {8'h00, irq_index[1:0], 1'b0};
            seq_q      <= mem_map_pkg::ST_VEC_LO;
          end else if (call_req) begin
            if (sp_q < 3'(mem_map_pkg::STACK_DEPTH)) begin
              stack_q[sp_q] <= pc_q + 12'h0001;
              sp_q          <= sp_q + 3'd1;
            end
            pc_q <= call_target;
          end else if (ret_req && sp_q != 3'd0) begin
            pc_q <= stack_q[sp_q - 3'd1];
            sp_q <= sp_q - 3'd1;
          end else if (jump_req) begin
            pc_q <= call_target;
          end else begin
            pc_q <= pc_q + 12'h0001;
          end
        end
        mem_map_pkg::ST_PROG: begin
          seq_q <= mem_map_pkg::ST_PROG;
        end
        default: begin
          seq_q <= mem_map_pkg::ST_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // data space
  // ----------------------------------------------------------------
  // write-only page registers, undefined at reset so left unreset
  always_ff @(posedge clk) begin
    if (data_wr && data_addr == mem_map_pkg::WIN_REG_ADDR) begin
      window_position_register <= data_wdata[5:0];
    end
    if (data_wr && data_addr == mem_map_pkg::BANK_REG_ADDR) begin
      ram_page2_select_bit <= data_wdata[mem_map_pkg::RAM_PAGE2_BIT];
      ee_sel_q <= {data_wdata[mem_map_pkg::EE_PAGE1_BIT], data_wdata[mem_map_pkg::EE_PAGE0_BIT]};
    end
    if (data_wr && data_addr >= mem_map_pkg::RAM_LO && data_addr <= mem_map_pkg::RAM_HI) begin
      ram_q[6'(data_addr - mem_map_pkg::RAM_LO)] <= data_wdata;
    end
    // bank region routed to ram page 2
    if (data_wr && data_addr <= mem_map_pkg::BANK_HI && ram_page2_select_bit) begin
      page2_q[data_addr[5:0]] <= data_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_rdata  <= mem_map_pkg::RESET_BYTE;
      data_rvalid <= 1'b0;
      win_rd_q    <= 1'b0;
      win_ofs_q   <= '0;
    end else begin
      data_rvalid <= 1'b0;
      win_rd_q    <= 1'b0;
      if (win_rd_q) begin
        data_rdata  <= prog_rdata;
        data_rvalid <= 1'b1;
      end else if (data_rd && data_addr >= mem_map_pkg::WIN_LO && data_addr <= mem_map_pkg::WIN_HI) begin
        // window read takes one extra cycle for program memory
        win_rd_q  <= 1'b1;
        win_ofs_q <= data_addr[5:0];
      end else if (data_rd) begin
        data_rvalid <= 1'b1;
        if (data_addr <= mem_map_pkg::BANK_HI) begin
          // banked overlay; nothing selected reads undefined
          data_rdata <= ram_page2_select_bit ? page2_q[data_addr[5:0]] : mem_map_pkg::UNDEF_BYTE;
        end else if (data_addr >= mem_map_pkg::RAM_LO && data_addr <= mem_map_pkg::RAM_HI) begin
          data_rdata <= ram_q[6'(data_addr - mem_map_pkg::RAM_LO)];
        end else begin
          data_rdata <= mem_map_pkg::UNDEF_BYTE;
        end
      end
    end
  end

  // program memory address mux; window cycle borrows the fetch port
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_addr <= mem_map_pkg::RESET_VEC_LO;
    end else if (seq_q == mem_map_pkg::ST_VEC_LO || seq_q == mem_map_pkg::ST_RESET) begin
      prog_addr <= (seq_q == mem_map_pkg::ST_RESET) ? mem_map_pkg::RESET_VEC_LO : vec_addr_q + 12'h0001;
    end else if (data_rd && data_addr >= mem_map_pkg::WIN_LO && data_addr <= mem_map_pkg::WIN_HI) begin
      // register as upper bits, offset below
      prog_addr <= {window_position_register, data_addr[5:0]};
    end else if (seq_q == mem_map_pkg::ST_RUN && (nmi_pending || irq_take)) begin
      prog_addr <= nmi_pending ? mem_map_pkg::NMI_VEC_LO
                 : mem_map_pkg::IRQ_VEC_BASE + {8'h00, irq_index[1:0], 1'b0};
    end else begin
      prog_addr <= pc_q;
    end
  end

  // ----------------------------------------------------------------
  // status and protection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      program_counter  <= '0;
      stack_level      <= '0;
      ext_read_blocked <= 1'b0;
    end else begin
      program_counter  <= pc_q;
      stack_level      <= sp_q;
      ext_read_blocked <= ext_read_req & readout_protect;
    end
  end

  // ----------------------------------------------------------------
  // port lines and alternate functions
  // ----------------------------------------------------------------
  always_comb begin
    alt_en  = '0;
    alt_out = '0;
    alt_en[port_b_bit7]  = timer_out_sel;
    alt_out[port_b_bit7] = reload_timer_output;
    // timer on c1, serial out and clock on c3, c4
    alt_en[port_c_bit1]  = timer1_alt_en;
    alt_out[port_c_bit1] = timer1_out;
    alt_en[port_c_bit3]  = spi_alt_en;
    alt_out[port_c_bit3] = spi_dout;
    alt_en[port_c_bit4]  = spi_alt_en;
    alt_out[port_c_bit4] = spi_clk_out;
  end

  for (genvar i = 0; i < NLINES; i++) begin : g_line
    port_line u_line (
      .clk        (clk),
      .nrst       (nrst),
      .mode       (line_mode[i]),
      .data_out   (line_data[i]),
      .alt_en     (alt_en[i]),
      .alt_out    (alt_out[i]),
      .pad_in     (pad_in[i]),
      .pad_out    (pad_out_c[i]),
      .pad_oe     (pad_oe_c[i]),
      .pad_pullup (pullup_c[i]),
      .line_in    (in_c[i]),
      .irq_fall   (irq_c[i])
    );
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pad_out            <= '0;
      pad_oe             <= '0;
      pad_pullup         <= '0;
      line_in            <= '0;
      line_irq           <= '0;
      reload_timer_input <= 1'b0;
      spi_din            <= 1'b0;
    end else begin
      pad_out    <= pad_out_c;
      pad_oe     <= pad_oe_c;
      pad_pullup <= pullup_c;
      line_in    <= in_c;
      line_irq   <= irq_c;
      // b6 feeds timer only in pull-up or floating input mode, not in irq mode
      reload_timer_input <= (line_mode[port_b_bit6] == mem_map_pkg::PM_IN_PULLUP ||
                             line_mode[port_b_bit6] == mem_map_pkg::PM_IN_FLOAT) ?
                            pad_in[port_b_bit6] : 1'b0;
      spi_din <= spi_alt_en ? pad_in[port_c_bit2] : 1'b0;
    end
  end
endmodule // mcu_memory_map_decode

// ==== hdl/mem_map_pkg.sv ====
// constants for the data and program space decoder
package mem_map_pkg;
  // program space
  localparam int          PC_W          = 12;
  localparam logic [11:0] RESET_VEC_LO  = 12'h0FFE;
  localparam logic [11:0] RESET_VEC_HI  = 12'h0FFF;
  localparam logic [11:0] NMI_VEC_LO    = 12'h0FFC;
  localparam logic [11:0] NMI_VEC_HI    = 12'h0FFD;
  localparam logic [11:0] IRQ_VEC_BASE  = 12'h0FF0;
  localparam logic [11:0] IRQ_VEC_LAST  = 12'h0FF7;
  localparam logic [7:0]  ERASED_BYTE   = 8'h00FF;
  localparam int          STACK_DEPTH   = 6;
  // data space
  localparam logic [7:0]  BANK_LO       = 8'h0000;
  localparam logic [7:0]  BANK_HI       = 8'h003F;
  localparam logic [7:0]  WIN_LO        = 8'h0040;
  localparam logic [7:0]  WIN_HI        = 8'h007F;
  localparam logic [7:0]  RAM_LO        = 8'h0084;
  localparam logic [7:0]  RAM_HI        = 8'h00BF;
  localparam logic [7:0]  WIN_REG_ADDR  = 8'h00C9;
  localparam logic [7:0]  BANK_REG_ADDR = 8'h00E8;
  localparam int          WIN_OFS_W     = 6;
  localparam int          RAM_PAGE2_BIT = 4;
  localparam int          EE_PAGE1_BIT  = 1;
  localparam int          EE_PAGE0_BIT  = 0;
  localparam logic [7:0]  UNDEF_BYTE    = 8'h00FF;
  localparam logic [7:0]  RESET_BYTE    = 8'h0000;
  // port line modes
  typedef enum logic [2:0] {
    PM_IN_PULLUP, PM_IN_FLOAT, PM_IN_IRQ, PM_OUT_OD, PM_OUT_PP, PM_ANALOG
  } pin_mode_e;
  // core sequencer
  typedef enum logic [2:0] {
    ST_RESET, ST_VEC_LO, ST_VEC_HI, ST_RUN, ST_PROG
  } seq_e;
endpackage : mem_map_pkg

// ==== hdl/port_line.sv ====
// one configurable i/o line with optional alternate output
`timescale 1ns/1ps
module port_line (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // configuration
  input  wire mem_map_pkg::pin_mode_e mode,
  input  wire logic                   data_out,
  input  wire logic                   alt_en,
  input  wire logic                   alt_out,
  // pad
  input  wire logic                   pad_in,
  output logic                        pad_out,
  output logic                        pad_oe,
  output logic                        pad_pullup,
  output logic                        line_in,
  output logic                        irq_fall
);
  logic prev_q;
  logic drive;

  always_comb begin
    drive = alt_en ? alt_out : data_out;
    case (mode)
      mem_map_pkg::PM_OUT_PP: begin
        pad_oe     = 1'b1;
        pad_pullup = 1'b0;
      end
      // open drain only drives the low level
      mem_map_pkg::PM_OUT_OD: begin
        pad_oe     = ~drive;
        pad_pullup = 1'b0;
      end
      mem_map_pkg::PM_IN_PULLUP, mem_map_pkg::PM_IN_IRQ: begin
        pad_oe     = alt_en;
        pad_pullup = 1'b1;
      end
      default: begin
        pad_oe     = alt_en;
        pad_pullup = 1'b0;
      end
    endcase
    pad_out = drive;
    line_in = (mode == mem_map_pkg::PM_ANALOG) ? 1'b0 : pad_in;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= pad_in;
    end
  end

  assign irq_fall = (mode == mem_map_pkg::PM_IN_IRQ) & prev_q & ~pad_in;
endmodule // port_line

// ==== sim/mem_map_monitor.sv ====
// concurrent checks on the memory map decoder ports
`timescale 1ns/1ps
module mem_map_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // events and requests
  input wire logic        nmi_pin,
  input wire logic        readout_protect,
  input wire logic        ext_read_req,
  input wire logic        irq_take,
  input wire logic        call_req,
  input wire logic        ret_req,
  input wire logic        jump_req,
  input wire logic [11:0] call_target,
  // data space
  input wire logic        data_wr,
  input wire logic        data_rd,
  input wire logic [7:0]  data_addr,
  input wire logic [7:0]  data_wdata,
  input wire logic [7:0]  data_rdata,
  input wire logic        data_rvalid,
  // status
  input wire logic [11:0] prog_addr,
  input wire logic [11:0] program_counter,
  input wire logic [2:0]  stack_level,
  input wire logic        nmi_pending,
  input wire logic        ext_read_blocked
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ----
  // shadows of the write-only registers
  // ----
  logic [5:0] win_q;
  logic [7:0] bank_q;
  logic       win_ok_q;
  logic       bank_ok_q;
  logic       quiet;
  // registers are not reset, so only judge after a write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      win_ok_q  <= 1'b0;
      bank_ok_q <= 1'b0;
    end else begin
      if (data_wr && data_addr == mem_map_pkg::WIN_REG_ADDR) win_ok_q <= 1'b1;
      if (data_wr && data_addr == mem_map_pkg::BANK_REG_ADDR) bank_ok_q <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (data_wr && data_addr == mem_map_pkg::WIN_REG_ADDR) win_q <= data_wdata[5:0];
    if (data_wr && data_addr == mem_map_pkg::BANK_REG_ADDR) bank_q <= data_wdata;
  end
  assign quiet = !irq_take && !nmi_pending && !jump_req;
  // ----
  // properties
  // ----
  sequence win_read_s;
    data_rd && data_addr[7:6] == 2'b01;
  endsequence
  sequence late_answer_s;
    !data_rvalid ##1 data_rvalid;
  endsequence
  blocked_flag_a: assert property (
    ##1 ext_read_blocked == $past(ext_read_req && readout_protect)) else $error("block flag wrong");
  nmi_edge_a: assert property (
    $fell(nmi_pin) |-> ##[1:3] nmi_pending) else $error("nmi edge not latched");
  plain_answer_a: assert property (
    data_rd && data_addr[7:6] != 2'b01 |=> data_rvalid) else $error("read answer late");
  win_answer_a: assert property (
    win_read_s |=> late_answer_s) else $error("window answer timing wrong");
  answer_cause_a: assert property (
    data_rvalid |-> $past(data_rd) || $past(data_rd, 2)) else $error("answer without read");
  win_addr_a: assert property (
    win_read_s ##0 win_ok_q |=> prog_addr == {win_q, $past(data_addr[5:0])})
    else $error("window address wrong");
  bank_undef_a: assert property (
    data_rd && data_addr <= mem_map_pkg::BANK_HI && bank_ok_q && !bank_q[4]
    |=> data_rdata == mem_map_pkg::UNDEF_BYTE) else $error("unbanked read not undefined");
  stack_bound_a: assert property (
    stack_level <= 3'd6) else $error("stack level above six");
  // status copies lag the stack pointer by one cycle
  sequence call_seen_s;
    call_req && !ret_req && quiet ##1 stack_level < 3'd6;
  endsequence
  sequence ret_seen_s;
    ret_req && !call_req && quiet ##1 stack_level != 3'd0;
  endsequence
  call_push_a: assert property (
    call_seen_s |=> stack_level == $past(stack_level) + 3'd1
    && program_counter == $past(call_target, 2)) else $error("call push wrong");
  ret_pop_a: assert property (
    ret_seen_s |=> stack_level == $past(stack_level) - 3'd1) else $error("return pop wrong");
endmodule // mem_map_monitor
bind mcu_memory_map_decode mem_map_monitor mon (.*);

// ==== sim/testbench.sv ====
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
module testbench;
  // ----
  // signals
  // ----
  logic        clk, nrst, test_raised, nmi_pin, readout_protect, ext_read_req;
  logic        irq_take, call_req, ret_req, jump_req, data_wr, data_rd, data_rvalid;
  logic        timer_out_sel, reload_timer_output, timer1_out, timer1_alt_en;
  logic        spi_alt_en, spi_dout, spi_clk_out, reload_timer_input, spi_din;
  logic        prog_mode, nmi_pending, ext_read_blocked, b;
  logic [2:0]  irq_index, stack_level;
  logic [7:0]  prog_rdata, data_addr, data_wdata, data_rdata;
  logic [11:0] call_target, prog_addr, program_counter;
  logic [20:0] line_data, pad_in, pad_out, pad_oe, pad_pullup, line_in, line_irq;
  int          n_fail, comparisons;
  mem_map_pkg::pin_mode_e line_mode [21];
  typedef struct {
    mem_map_pkg::pin_mode_e m;
    logic                   d, oe, pu;
  } mode_row_s;
  mode_row_s   rows [8] = '{'{mem_map_pkg::PM_IN_PULLUP, 1'b0, 1'b0, 1'b1},
    '{mem_map_pkg::PM_IN_FLOAT, 1'b0, 1'b0, 1'b0}, '{mem_map_pkg::PM_IN_IRQ, 1'b0, 1'b0, 1'b1},
    '{mem_map_pkg::PM_OUT_OD, 1'b0, 1'b1, 1'b0}, '{mem_map_pkg::PM_OUT_OD, 1'b1, 1'b0, 1'b0},
    '{mem_map_pkg::PM_OUT_PP, 1'b0, 1'b1, 1'b0}, '{mem_map_pkg::PM_OUT_PP, 1'b1, 1'b1, 1'b0},
    '{mem_map_pkg::PM_ANALOG, 1'b0, 1'b0, 1'b0}};
  mcu_memory_map_decode dut (.*);
  // program image: vectors, erased reserved areas, a pattern elsewhere
  function automatic logic [7:0] pmem(input logic [11:0] a);
    if (a >= 12'h0FF0 && a <= 12'h0FF7) return a[0] ? 8'hF4 : {a[2:1], 6'h00};
    if (a == 12'h0FFC) return 8'h56;
    if (a == 12'h0FFD) return 8'hF3;
    if (a == 12'h0FFE) return 8'h34;
    if (a == 12'h0FFF) return 8'hF2;
    if (a < 12'h0080 || a >= 12'h0FA0) return 8'hFF;
    return a[7:0] ^ {a[11:8], 4'h0};
  endfunction
  assign prog_rdata = pmem(prog_addr);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----
  // tasks
  // ----
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_pc(logic [11:0] exp);
    for (int i = 0; i < 16 && program_counter !== exp; i++) tick();
    chk("program_counter", program_counter, exp);
    if (program_counter !== exp) complete_run();
  endtask
  task automatic req(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    data_addr = a;
    data_wdata = d;
    req(data_wr);
    tick();
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    data_addr = a;
    req(data_rd);
    for (int i = 0; i < 3 && data_rvalid !== 1'b1; i++) tick();
    chk("data_rvalid", data_rvalid, 1'b1);
    if (data_rvalid !== 1'b1) complete_run();
    chk("data_rdata", data_rdata, exp);
    tick();
  endtask
  task automatic do_reset(logic raised);
    nrst = 1'b0;
    test_raised = raised;
    tick(3);
    nrst = 1'b1;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    {nmi_pin, pad_in} = {1'b1, 21'h1F_FFFF};
    {readout_protect, ext_read_req, irq_take, call_req, ret_req, jump_req} = '0;
    {data_wr, data_rd, timer_out_sel, reload_timer_output, timer1_out, timer1_alt_en} = '0;
    {spi_alt_en, spi_dout, spi_clk_out, irq_index, call_target, line_data} = '0;
    {data_addr, data_wdata, n_fail, comparisons} = '0;
    foreach (line_mode[k]) line_mode[k] = mem_map_pkg::PM_IN_PULLUP;
    do_reset(1'b0);
    chk("prog_addr", prog_addr, 12'h0FFE);
    wait_pc(12'h0234);
    for (int i = 0; i < 8; i++) begin
      foreach (line_mode[k]) line_mode[k] = rows[i].m;
      line_data = {21{rows[i].d}};
      tick(2);
      chk("pad_oe", pad_oe, {21{rows[i].oe}});
      chk("pad_pullup", pad_pullup, {21{rows[i].pu}});
      if (rows[i].oe) chk("pad_out", pad_out, {21{rows[i].d}});
    end
    $display("test port modes done");
    foreach (line_mode[k]) line_mode[k] = mem_map_pkg::PM_OUT_PP;
    line_mode[14] = mem_map_pkg::PM_IN_FLOAT;
    line_mode[18] = mem_map_pkg::PM_IN_FLOAT;
    {timer_out_sel, timer1_alt_en, spi_alt_en} = 3'b111;
    for (int v = 0; v < 2; v++) begin
      b = v[0];
      {reload_timer_output, timer1_out, spi_dout, spi_clk_out} = {b, b, b, !b};
      {pad_in[14], pad_in[18], line_data} = {b, !b, {21{!b}}};
      tick(2);
      chk("timer_out", pad_out[15], b);
      chk("timer_in", reload_timer_input, b);
      chk("timer1_line", pad_out[17], b);
      chk("spi_in", spi_din, !b);
      chk("spi_lines", pad_out[20:19], {!b, b});
    end
    $display("test alternate lines done");
    foreach (line_mode[k]) line_mode[k] = mem_map_pkg::PM_IN_IRQ;
    {timer_out_sel, timer1_alt_en, spi_alt_en} = 3'b000;
    pad_in = 21'h1F_FFFF;
    tick(2);
    chk("line_in", line_in, 21'h1F_FFFF);
    pad_in = 21'h00_0000;
    tick();
    chk("line_irq", line_irq, 21'h1F_FFFF);
    tick();
    chk("line_irq", line_irq, 21'h00_0000);
    chk("line_in", line_in, 21'h00_0000);
    foreach (line_mode[k]) line_mode[k] = mem_map_pkg::PM_ANALOG;
    pad_in = 21'h1F_FFFF;
    tick(2);
    chk("line_in", line_in, 21'h00_0000);
    $display("test line inputs done");
    nmi_pin = 1'b0;
    wait_pc(12'h0356);
    chk("stack_level", stack_level, 1);
    req(ret_req);
    nmi_pin = 1'b1;
    tick(2);
    chk("nmi_pending", nmi_pending, 0);
    for (int k = 0; k < 4; k++) begin
      irq_index = k[2:0];
      req(irq_take);
      wait_pc(12'h0400 + 12'(k * 64));
      chk("stack_level", stack_level, 1);
      req(ret_req);
      tick();
    end
    $display("test vectors done");
    for (int k = 0; k < 7; k++) begin
      call_target = 12'h0100 + 12'(k);
      req(call_req);
      tick();
      chk("program_counter", program_counter, call_target);
      chk("stack_level", stack_level, (k < 6) ? k + 1 : 6);
    end
    for (int k = 0; k < 6; k++) begin
      req(ret_req);
      tick();
      chk("stack_level", stack_level, 5 - k);
      if (k < 5) chk("program_counter", program_counter, 12'h0106 - 12'(k));
    end
    $display("test stack done");
    wr(8'hE8, 8'h10);
    wr(8'h00, 8'h3C);
    rd(8'h00, 8'h3C);
    wr(8'hE8, 8'h00);
    rd(8'h00, 8'hFF);
    wr(8'h84, 8'hA5);
    wr(8'hBF, 8'h5A);
    rd(8'h84, 8'hA5);
    rd(8'hBF, 8'h5A);
    rd(8'hC3, 8'hFF);
    wr(8'hC9, 8'h28);
    rd(8'h59, 8'hB9);
    wr(8'hC9, 8'h3F);
    rd(8'h7F, 8'hF2);
    $display("test data space done");
    {readout_protect, ext_read_req} = 2'b11;
    tick(2);
    chk("ext_read_blocked", ext_read_blocked, 1);
    readout_protect = 1'b0;
    tick(2);
    chk("ext_read_blocked", ext_read_blocked, 0);
    $display("test protection done");
    do_reset(1'b1);
    tick(3);
    test_raised = 1'b0;
    tick();
    chk("prog_mode", prog_mode, 1);
    do_reset(1'b0);
    wait_pc(12'h0234);
    chk("prog_mode", prog_mode, 0);
    $display("test reset modes done");
    complete_run();
  end
endmodule // testbench
